// ==== rtl/swl_cmd_top.sv ====
// Purpose: APB-driven read-byte and triplet commands for a single-wire master
// Assumes: APB master that waits for pready (one wait state per access); one selected channel
// Notes: a refused command answers with pslverr and changes nothing
//        busy clears one cycle after the last slot's end pulse
`timescale 1ns/10ps
`default_nettype none
module swl_cmd_top (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // single-wire line
   input wire logic line_in,
   output logic line_out,
   output logic line_oe_n_out,
   output logic pullup_out
);
   typedef enum logic [2:0] {
      SWL_IDLE,
      SWL_RBYTE,
      SWL_TRD1,
      SWL_TRD2,
      SWL_TWR
   } swl_state_t;

   swl_slot_if slot ();

   swl_state_t state_q;
   logic busy_q;
   logic [swl_pkg::BIT_CNT_W-1:0] bit_cnt_q;
   logic [7:0] rdata_q;
   logic sbr_q;
   logic tsb_q;
   logic dir_q;
   logic dir_value_q;
   logic start_q;
   logic wr_bit_q;
   logic cfg_apu_q;
   logic cfg_fast_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic access;
   logic cmd_wr;
   logic [7:0] cmd_code;
   logic cmd_known;
   logic accept_rbyte;
   logic accept_trip;
   logic next_dir;
   logic hit_cmd;
   logic hit_status;
   logic hit_rdata;
   logic hit_config;
   logic last_bit;
   logic [31:0] status_word;
   logic [31:0] config_word;
   logic pslverr_d;

   assign access = psel_in && penable_in && !pready_q;
   assign cmd_wr = access && pwrite_in && (paddr_in == swl_pkg::OFS_CMD);
   assign cmd_code = pwdata_in[swl_pkg::CMD_CODE_LSB +: 8];
   assign cmd_known = (cmd_code == swl_pkg::CMD_READ_BYTE) || (cmd_code == swl_pkg::CMD_TRIPLET);
   assign accept_rbyte = cmd_wr && !busy_q && (cmd_code == swl_pkg::CMD_READ_BYTE);
   assign accept_trip = cmd_wr && !busy_q && (cmd_code == swl_pkg::CMD_TRIPLET);

   // address decode; anything else is refused with pslverr
   assign hit_cmd = (paddr_in == swl_pkg::OFS_CMD);
   assign hit_status = (paddr_in == swl_pkg::OFS_STATUS);
   assign hit_rdata = (paddr_in == swl_pkg::OFS_RDATA);
   assign hit_config = (paddr_in == swl_pkg::OFS_CONFIG);
   assign last_bit = (bit_cnt_q == swl_pkg::BIT_CNT_W'(7));

   // read views of the status and config registers
   always_comb begin
      status_word = '0;
      status_word[swl_pkg::ST_BUSY_BIT] = busy_q;
      status_word[swl_pkg::ST_SBR_BIT] = sbr_q;
      status_word[swl_pkg::ST_TSB_BIT] = tsb_q;
      status_word[swl_pkg::ST_DIR_BIT] = dir_q;
      config_word = '0;
      config_word[swl_pkg::CFG_APU_BIT] = cfg_apu_q;
      config_word[swl_pkg::CFG_SPEED_BIT] = cfg_fast_q;
   end

   // busy or unknown commands and writes to read-only words are refused
   always_comb begin
      pslverr_d = 1'b0;
      if (access && pwrite_in) begin
         if (hit_cmd) begin
            pslverr_d = busy_q || !cmd_known;
         end else if (!hit_config) begin
            pslverr_d = 1'b1;
         end
      end else if (access) begin
         pslverr_d = !(hit_cmd || hit_status || hit_rdata || hit_config);
      end
   end

   always_comb begin
      if (sbr_q) begin
         next_dir = 1'b1;
      end else if (slot.sample_bit) begin
         next_dir = 1'b0;
      end else begin
         next_dir = dir_value_q;
      end
   end

   // apb handshake: answer one cycle into the access phase
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= access;
         pslverr_q <= pslverr_d;
         prdata_q <= '0;
         if (access && !pwrite_in) begin
            case (paddr_in)
               swl_pkg::OFS_STATUS: begin
                  prdata_q <= status_word;
               end
               swl_pkg::OFS_RDATA: begin
                  prdata_q[7:0] <= rdata_q;
               end
               swl_pkg::OFS_CONFIG: begin
                  prdata_q <= config_word;
               end
               swl_pkg::OFS_CMD: begin
                  prdata_q <= '0;
               end
               default: begin
                  prdata_q <= '0;
               end
            endcase
         end
      end
   end

   // configuration; changes made while busy take effect at the next slot
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         cfg_apu_q <= 1'b0;
         cfg_fast_q <= 1'b0;
      end else if (access && pwrite_in && (paddr_in == swl_pkg::OFS_CONFIG)) begin
         cfg_apu_q <= pwdata_in[swl_pkg::CFG_APU_BIT];
         cfg_fast_q <= pwdata_in[swl_pkg::CFG_SPEED_BIT];
      end
   end

   // command sequencer
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         state_q <= SWL_IDLE;
         busy_q <= 1'b0;
         bit_cnt_q <= '0;
         start_q <= 1'b0;
         wr_bit_q <= 1'b1;
         dir_value_q <= 1'b0;
      end else begin
         start_q <= 1'b0;
         case (state_q)
            SWL_IDLE: begin
               // eight write-one slots, first starts next cycle
               if (accept_rbyte) begin
                  state_q <= SWL_RBYTE;
                  busy_q <= 1'b1;
                  bit_cnt_q <= '0;
                  start_q <= 1'b1;
                  wr_bit_q <= 1'b1;
               // triplet starts with a read slot
               end else if (accept_trip) begin
                  state_q <= SWL_TRD1;
                  busy_q <= 1'b1;
                  start_q <= 1'b1;
                  wr_bit_q <= 1'b1;
                  dir_value_q <= pwdata_in[swl_pkg::CMD_PARAM_LSB + swl_pkg::DIR_VALUE_BIT];
               end
            end
            SWL_RBYTE: begin
               // busy until the eighth slot ends
               if (slot.done) begin
                  if (last_bit) begin
                     state_q <= SWL_IDLE;
                     busy_q <= 1'b0;
                  end else begin
                     bit_cnt_q <= bit_cnt_q + 1'b1;
                     start_q <= 1'b1;
                  end
               end
            end
            SWL_TRD1: begin
               if (slot.done) begin
                  state_q <= SWL_TRD2;
                  start_q <= 1'b1;
               end
            end
            SWL_TRD2: begin
               // write slot chosen at the second sample point
               if (slot.sample) begin
                  wr_bit_q <= next_dir;
               end
               if (slot.done) begin
                  state_q <= SWL_TWR;
                  start_q <= 1'b1;
               end
            end
            SWL_TWR: begin
               // busy until the write slot ends
               if (slot.done) begin
                  state_q <= SWL_IDLE;
                  busy_q <= 1'b0;
                  wr_bit_q <= 1'b1;
               end
            end
            default: begin
               state_q <= SWL_IDLE;
               busy_q <= 1'b0;
            end
         endcase
      end
   end

   // results captured at the sample points
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         rdata_q <= '0;
         sbr_q <= 1'b0;
         tsb_q <= 1'b0;
         dir_q <= 1'b0;
      end else if (slot.sample) begin
         // first bit received lands in bit 0
         if (state_q == SWL_RBYTE) begin
            rdata_q <= {slot.sample_bit, rdata_q[7:1]};
         end
         if (state_q == SWL_TRD1) begin
            sbr_q <= slot.sample_bit;
         end
         if (state_q == SWL_TRD2) begin
            tsb_q <= slot.sample_bit;
            dir_q <= next_dir;
         end
      end
   end

   // speed and active pullup follow config; no strong pullup path
   assign slot.start = start_q;
   assign slot.wr_bit = wr_bit_q;
   assign slot.speed_fast = cfg_fast_q;
   assign slot.apu_en = cfg_apu_q;

   // pins leave straight from the slot generator's flops
   swl_slot_gen u_slot_gen (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .slot(slot),
      .line_in(line_in),
      .line_out(line_out),
      .line_oe_n_out(line_oe_n_out),
      .pullup_out(pullup_out)
   );

   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;
endmodule
`default_nettype wire

// ==== rtl/swl_pkg.sv ====
// Purpose: shared constants for the single-wire read-byte and triplet engine
// Assumes: 20 MHz system clock, APB register access with 32-bit data
// Notes: slot timings are plain defaults, set to the actual line speeds in use
package swl_pkg;
   // clock
   localparam int CLK_PERIOD_NS = 50;
   // command codes
   localparam logic [7:0] CMD_READ_BYTE = 8'h96;
   localparam logic [7:0] CMD_TRIPLET = 8'h78;
   // register byte offsets
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_RDATA = 8'h08;
   localparam logic [7:0] OFS_CONFIG = 8'h0c;
   // command register fields
   localparam int CMD_CODE_LSB = 0;
   localparam int CMD_PARAM_LSB = 8;
   localparam int DIR_VALUE_BIT = 7;
   // status register fields
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_SBR_BIT = 5;
   localparam int ST_TSB_BIT = 6;
   localparam int ST_DIR_BIT = 7;
   // config register fields
   localparam int CFG_APU_BIT = 0;
   localparam int CFG_SPEED_BIT = 3;
   // slot timings, standard speed
   localparam int STD_SLOT_NS = 70000;
   localparam int STD_W1L_NS = 6000;
   localparam int STD_W0L_NS = 60000;
   localparam int STD_MSR_NS = 10000;
   // slot timings, fast speed
   localparam int FST_SLOT_NS = 10000;
   localparam int FST_W1L_NS = 1000;
   localparam int FST_W0L_NS = 7500;
   localparam int FST_MSR_NS = 1500;
   // active pullup pulse after release
   localparam int APU_NS = 2500;
   // longest allowed delay from command to line activity, in ps
   localparam int START_MAX_PS = 262500;
   localparam int START_MAX_CYC = START_MAX_PS / (CLK_PERIOD_NS * 1000);
   // cycle counts (low times and sample point are least times: round up)
   localparam int STD_SLOT_CYC = (STD_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STD_W1L_CYC = (STD_W1L_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STD_W0L_CYC = (STD_W0L_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STD_MSR_CYC = (STD_MSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FST_SLOT_CYC = (FST_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FST_W1L_CYC = (FST_W1L_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FST_W0L_CYC = (FST_W0L_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FST_MSR_CYC = (FST_MSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int APU_CYC = (APU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 11;
   localparam int BIT_CNT_W = 3;
endpackage

// ==== rtl/swl_slot_if.sv ====
// Purpose: carrier between the command sequencer and the slot generator
// Assumes: single clock domain
// Notes: start and sample are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
interface swl_slot_if;
   logic start;
   logic wr_bit;
   logic speed_fast;
   logic apu_en;
   logic sample;
   logic sample_bit;
   logic done;
   modport seq (output start, output wr_bit, output speed_fast, output apu_en,
      input sample, input sample_bit, input done);
   modport gen (input start, input wr_bit, input speed_fast, input apu_en,
      output sample, output sample_bit, output done);
endinterface
`default_nettype wire

// ==== rtl/swl_slot_gen.sv ====
// Purpose: generates one single-wire time slot per start pulse
// Assumes: start only while idle; line input is asynchronous
// Notes: recovery time is part of the slot period
`timescale 1ns/10ps
`default_nettype none
module swl_slot_gen (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_in,
   // sequencer side
   swl_slot_if.gen slot,
   // line pins
   input wire logic line_in,
   output logic line_out,
   output logic line_oe_n_out,
   output logic pullup_out
);
   logic [swl_pkg::CNT_W-1:0] cnt_q;
   logic active_q;
   logic wr_bit_q;
   logic fast_q;
   logic apu_q;
   logic sync1_q;
   logic sync2_q;
   logic sample_q;
   logic sample_bit_q;
   logic done_q;
   logic [swl_pkg::CNT_W-1:0] low_len;
   logic [swl_pkg::CNT_W-1:0] slot_len;
   logic [swl_pkg::CNT_W-1:0] msr_len;

   always_comb begin
      if (fast_q) begin
         slot_len = swl_pkg::CNT_W'(swl_pkg::FST_SLOT_CYC);
         msr_len = swl_pkg::CNT_W'(swl_pkg::FST_MSR_CYC);
         low_len = wr_bit_q ? swl_pkg::CNT_W'(swl_pkg::FST_W1L_CYC) : swl_pkg::CNT_W'(swl_pkg::FST_W0L_CYC);
      end else begin
         slot_len = swl_pkg::CNT_W'(swl_pkg::STD_SLOT_CYC);
         msr_len = swl_pkg::CNT_W'(swl_pkg::STD_MSR_CYC);
         low_len = wr_bit_q ? swl_pkg::CNT_W'(swl_pkg::STD_W1L_CYC) : swl_pkg::CNT_W'(swl_pkg::STD_W0L_CYC);
      end
   end

   // two-stage synchroniser on the line
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
      end else begin
         sync1_q <= line_in;
         sync2_q <= sync1_q;
      end
   end

   // slot timer; settings latched so a mid-slot config write cannot warp it
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         active_q <= 1'b0;
         cnt_q <= '0;
         wr_bit_q <= 1'b1;
         fast_q <= 1'b0;
         apu_q <= 1'b0;
      end else if (slot.start && !active_q) begin
         active_q <= 1'b1;
         cnt_q <= '0;
         wr_bit_q <= slot.wr_bit;
         fast_q <= slot.speed_fast;
         apu_q <= slot.apu_en;
      end else if (active_q) begin
         cnt_q <= cnt_q + 1'b1;
         if (cnt_q == slot_len - 1'b1) begin
            active_q <= 1'b0;
         end
      end
   end

   // sample point and end-of-slot pulses
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         sample_q <= 1'b0;
         sample_bit_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         sample_q <= active_q && (cnt_q == msr_len);
         done_q <= active_q && (cnt_q == slot_len - 1'b1);
         if (active_q && (cnt_q == msr_len)) begin
            sample_bit_q <= sync2_q;
         end
      end
   end

   // open-drain drive; only the sample pulse tells the slave's answer
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         line_out <= 1'b0;
         line_oe_n_out <= 1'b1;
         pullup_out <= 1'b0;
      end else begin
         line_out <= 1'b0;
         if (slot.start && !active_q) begin
            line_oe_n_out <= 1'b0;
         end else begin
            line_oe_n_out <= !(active_q && (cnt_q + 1'b1 < low_len));
         end
         pullup_out <= apu_q && active_q && (cnt_q + 1'b1 >= low_len) &&
            (cnt_q + 1'b1 < low_len + swl_pkg::CNT_W'(swl_pkg::APU_CYC));
      end
   end

   assign slot.sample = sample_q;
   assign slot.sample_bit = sample_bit_q;
   assign slot.done = done_q;
endmodule
`default_nettype wire

// ==== tb/swl_cmd_props.sv ====
// Purpose: port assertions for swl_cmd_top
// Assumes: apb answer comes one cycle after the take edge
// Notes: busy is not visible here, so refusals are judged by the bench
`timescale 1ns/10ps
`default_nettype none
module swl_cmd_props (
   // clock, reset and apb
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // line
   input wire logic line_in,
   input wire logic line_out,
   input wire logic line_oe_n_out,
   input wire logic pullup_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   logic [11:0] low_q;
   // length of the current low drive
   always_ff @(posedge ref_clk_in) begin
      if (reset_in || line_oe_n_out) begin
         low_q <= 12'h000;
      end else begin
         low_q <= low_q + 12'h001;
      end
   end
   sequence s_take;
      psel_in && penable_in && !pready_out;
   endsequence
   sequence s_cmd_ok;
      pready_out && pwrite_in && !pslverr_out && paddr_in == swl_pkg::OFS_CMD;
   endsequence
   property p_answer;
      s_take |=> pready_out;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer after access");
   property p_one;
      pready_out |=> !pready_out;
   endproperty
   a_one: assert property (p_one) else $error("ready longer than one cycle");
   property p_err;
      pslverr_out |-> pready_out;
   endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_start;
      s_cmd_ok ##0 (pwdata_in[7:0] == swl_pkg::CMD_READ_BYTE || pwdata_in[7:0] == swl_pkg::CMD_TRIPLET)
         |-> ##[1:5] !line_oe_n_out;
   endproperty
   a_start: assert property (p_start) else $error("line activity late");
   property p_low_min;
      $fell(line_oe_n_out) |-> !line_oe_n_out [*8];
   endproperty
   a_low_min: assert property (p_low_min) else $error("slot low too short");
   property p_low_max;
      int'(low_q) <= swl_pkg::STD_W0L_CYC + 1;
   endproperty
   a_low_max: assert property (p_low_max) else $error("slot low too long");
   property p_recover;
      $rose(line_oe_n_out) |-> line_oe_n_out [*8];
   endproperty
   a_recover: assert property (p_recover) else $error("no recovery after slot");
   property p_no_pu;
      !line_oe_n_out |-> !pullup_out && !line_out;
   endproperty
   a_no_pu: assert property (p_no_pu) else $error("pullup while driving");
   property p_unmapped;
      pready_out && paddr_in > swl_pkg::OFS_CONFIG |-> pslverr_out && prdata_out == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access answered");
   property p_ro;
      pready_out && pwrite_in && (paddr_in == swl_pkg::OFS_STATUS || paddr_in == swl_pkg::OFS_RDATA) |-> pslverr_out;
   endproperty
   a_ro: assert property (p_ro) else $error("read-only write accepted");
endmodule
`default_nettype wire

// ==== tb/swl_slave_model.sv ====
// Purpose: slave devices on the single-wire line
// Assumes: line has a pullup; a slot starts when the master drive falls
// Notes: hold_in is the reply low time and also the write-zero threshold
`timescale 1ns/10ps
`default_nettype none
module swl_slave_model (
   // clock and control
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic load_in,
   input wire logic [7:0] resp_in,
   input wire logic [11:0] hold_in,
   // line and results
   input wire logic line_oe_n_in,
   output logic pull_out,
   output logic [7:0] seen_out,
   output logic [7:0] slots_out
);
   logic [7:0] resp_q;
   logic [11:0] hold_q;
   logic [11:0] low_q;
   logic prev_q;
   always_ff @(posedge clk_in) begin
      prev_q <= line_oe_n_in;
      if (reset_in || load_in) begin
         resp_q <= resp_in;
         hold_q <= 12'h000;
         low_q <= 12'h000;
         pull_out <= 1'b0;
         seen_out <= 8'h00;
         slots_out <= 8'h00;
      end else if (prev_q && !line_oe_n_in) begin
         pull_out <= !resp_q[0];
         resp_q <= {1'b1, resp_q[7:1]};
         hold_q <= hold_in;
         low_q <= 12'h001;
         slots_out <= slots_out + 8'h01;
      end else begin
         if (hold_q == 12'h001) pull_out <= 1'b0;
         if (hold_q != 12'h000) hold_q <= hold_q - 12'h001;
         if (!line_oe_n_in) low_q <= low_q + 12'h001;
         if (!prev_q && line_oe_n_in) seen_out <= {low_q < hold_in, seen_out[7:1]};
      end
   end
endmodule
`default_nettype wire

// ==== tb/swl_cmd_top_test.sv ====
// Purpose: self-checking bench for swl_cmd_top
// Assumes: fast slots for the triplet table
// Notes: busy and results are read back over apb
`timescale 1ns/10ps
`default_nettype none
module swl_cmd_top_test;
   typedef struct packed {logic [1:0] r; logic [7:0] dir; logic exp;} swl_row_t;
   localparam swl_row_t ROWS [8] = '{'{2'h0, 8'h7f, 1'b0}, '{2'h0, 8'h80, 1'b1}, '{2'h2, 8'h7f, 1'b0},
      '{2'h2, 8'hff, 1'b0}, '{2'h1, 8'h00, 1'b1}, '{2'h1, 8'h80, 1'b1}, '{2'h3, 8'h7f, 1'b1}, '{2'h3, 8'h80, 1'b1}};
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, load = 1'b0, pu_seen = 1'b0;
   logic [7:0] paddr = 8'h00, resp = 8'hff, seen, slots;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [11:0] hold = 12'h03c;
   logic pready, pslverr, line_o, oe_n, pu, pull, line, err;
   int fails = 0, n_checks = 0, cyc = 0, t0, i, c;
   always #25 clk = ~clk;
   assign line = (oe_n | line_o) & ~pull;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (load) begin
         pu_seen <= 1'b0;
      end else if (pu === 1'b1) begin
         pu_seen <= 1'b1;
      end
      // ceiling: 64 fast triplets, three read bytes and the reset case, with margin
      if (cyc == 80000) begin
         fails++;
         summarize();
      end
   end
   swl_cmd_top i_swl_cmd_top (.ref_clk_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .line_in(line), .line_out(line_o), .line_oe_n_out(oe_n), .pullup_out(pu));
   swl_slave_model i_swl_slave_model (.clk_in(clk), .reset_in(rst), .load_in(load), .resp_in(resp),
      .hold_in(hold), .line_oe_n_in(oe_n), .pull_out(pull), .seen_out(seen), .slots_out(slots));
   task automatic summarize();
      $display("checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   task automatic chk_rng(input string name, input int lo, input int hi, input int got);
      n_checks++;
      if (got < lo || got > hi) begin
         fails++;
         $display("unexpected %s: expected %0d..%0d, seen %0d", name, lo, hi, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic idle();
      t0 = cyc;
      do apb(1'b0, swl_pkg::OFS_STATUS, 32'h0); while (rd[swl_pkg::ST_BUSY_BIT] !== 1'b0);
      c = cyc - t0;
   endtask
   task automatic prime(input logic [7:0] v);
      resp <= v;
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
   endtask
   task automatic rbyte(input logic [31:0] cfg, input logic [7:0] v, input int s);
      apb(1'b1, swl_pkg::OFS_CONFIG, cfg);
      prime(v);
      apb(1'b1, swl_pkg::OFS_CMD, {24'h0, swl_pkg::CMD_READ_BYTE});
      chk("accept", 32'h0, {31'h0, err});
      apb(1'b0, swl_pkg::OFS_STATUS, 32'h0);
      chk("busy", 32'h1, {31'h0, rd[0]});
      apb(1'b1, swl_pkg::OFS_CMD, {24'h0, swl_pkg::CMD_TRIPLET});
      chk("refuse", 32'h1, {31'h0, err});
      idle();
      chk_rng("duration", 8 * s - 30, 8 * (s + 4) + 20, c);
      chk("slots", 32'h8, {24'h0, slots});
      chk("slot kind", 32'hff, {24'h0, seen});
      chk("pullup", {31'h0, cfg[0]}, {31'h0, pu_seen});
      apb(1'b0, swl_pkg::OFS_RDATA, 32'h0);
      chk("data", {24'h0, v}, {24'h0, rd[7:0]});
      $display("read byte cfg %h done", cfg);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("reset drive", 32'h1, {31'h0, oe_n});
      apb(1'b1, swl_pkg::OFS_CONFIG, 32'h8);
      // a full search: 64 triplets in succession, the table eight times over
      for (i = 0; i < 64; i++) begin
         prime({6'h3f, ROWS[i % 8].r});
         apb(1'b1, swl_pkg::OFS_CMD, {16'h0, ROWS[i % 8].dir, swl_pkg::CMD_TRIPLET});
         apb(1'b1, swl_pkg::OFS_CMD, {24'h0, swl_pkg::CMD_READ_BYTE});
         chk("refuse", 32'h1, {31'h0, err});
         idle();
         chk_rng("duration", 3 * swl_pkg::FST_SLOT_CYC - 30, 3 * (swl_pkg::FST_SLOT_CYC + 4) + 20, c);
         chk("slots", 32'h3, {24'h0, slots});
         chk("write slot", {31'h0, ROWS[i % 8].exp}, {31'h0, seen[7]});
         chk("flags", {29'h0, ROWS[i % 8].exp, ROWS[i % 8].r}, {29'h0, rd[7:5]});
         $display("triplet row %0d done", i);
      end
      rbyte(32'h9, 8'ha5, swl_pkg::FST_SLOT_CYC);
      rbyte(32'h8, 8'h5a, swl_pkg::FST_SLOT_CYC);
      hold <= 12'h190;
      rbyte(32'h1, 8'h3c, swl_pkg::STD_SLOT_CYC);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h1, {rd[30:0], err});
      apb(1'b1, swl_pkg::OFS_STATUS, 32'h0);
      chk("status write", 32'h1, {31'h0, err});
      apb(1'b1, swl_pkg::OFS_CMD, 32'h55);
      chk("unknown code", 32'h1, {31'h0, err});
      $display("refusals done");
      apb(1'b1, swl_pkg::OFS_CMD, {24'h0, swl_pkg::CMD_READ_BYTE});
      repeat (300) @(posedge clk);
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("drive after reset", 32'h1, {31'h0, oe_n});
      apb(1'b0, swl_pkg::OFS_STATUS, 32'h0);
      chk("busy after reset", 32'h0, {31'h0, rd[0]});
      $display("mid-command reset done");
      summarize();
   end
endmodule
bind swl_cmd_top swl_cmd_props i_swl_cmd_props (.ref_clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in,
   .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .line_in, .line_out, .line_oe_n_out, .pullup_out);
`default_nettype wire
